// >>> src/lmtr_fifo.sv
`timescale 1ns/1ps
module lmtr_fifo #(
    parameter int WIDTH = 20,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic full, empty, push, pop;

    always_comb
    begin
        empty = (wr_ptr == rd_ptr);
        full = (wr_ptr[PTR_W-1:0] == rd_ptr[PTR_W-1:0]) && (wr_ptr[PTR_W] != rd_ptr[PTR_W]);
        push = in_valid_i && !full;
        pop = out_ready_i && !empty;
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    end

    assign in_ready_o = !full;
    assign out_valid_o = !empty;
    assign out_data_o = mem[rd_ptr[PTR_W-1:0]];

    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end

    // Storage needs no reset; empty flag guards reads
    always_ff @(posedge ref_clk_i)
    begin
        if (push)
            mem[wr_ptr[PTR_W-1:0]] <= in_data_i;
    end

endmodule : lmtr_fifo

// >>> src/lmtr_filter.sv
`timescale 1ns/1ps
module lmtr_filter
    import lmtr_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    // Sample in
    input wire logic in_valid_i,
    input wire logic signed [SMP_W-1:0] in_data_i,
    // Configuration
    input wire logic filter_enable_i,
    input wire logic filter_bandpass_select_i,
    input wire logic notch_coef_from_rom_i,
    input wire logic bandpass_coef_from_rom_i,
    input wire logic [COEF_SET_W-1:0] notch_ram_coef_i,
    input wire logic [COEF_SET_W-1:0] bandpass_ram_coef_i,
    // Sample out
    output logic out_valid_o,
    output logic signed [SMP_W-1:0] out_data_o
);
    logic signed [SMP_W-1:0] x1, x2, y1, y2, next_x1, next_x2, next_y1, next_y2;
    logic signed [SMP_W-1:0] next_out, bp, notch;
    logic signed [COEF_W-1:0] cg, ca1, ca2;
    logic [COEF_SET_W-1:0] coef;
    logic signed [39:0] wide;

    always_comb
    begin
        // ROM or RAM coefficients per response
        if (filter_bandpass_select_i)
            coef = bandpass_coef_from_rom_i ? BP_ROM_COEF : bandpass_ram_coef_i; // see [R07]
        else
            coef = notch_coef_from_rom_i ? NOTCH_ROM_COEF : notch_ram_coef_i; // see [R07]
        cg = coef[3*COEF_W-1:2*COEF_W];
        ca2 = coef[2*COEF_W-1:COEF_W];
        ca1 = coef[COEF_W-1:0];
        // Resonator; centre and Q of 5 set by the coefficients
        wide = 40'(cg) * (40'(in_data_i) - 40'(x2)) + 40'(ca1) * 40'(y1)
            - 40'(ca2) * 40'(y2); // see [R08]
        bp = lmtr_sat16(wide >>> COEF_FRAC);
        notch = lmtr_sat16(40'(in_data_i) - 40'(bp));
        next_x1 = x1;
        next_x2 = x2;
        next_y1 = y1;
        next_y2 = y2;
        next_out = out_data_o;
        if (in_valid_i)
        begin
            next_x1 = in_data_i;
            next_x2 = x1;
            next_y1 = bp;
            next_y2 = y1;
            if (!filter_enable_i)
                next_out = in_data_i; // see [R06]
            else
                next_out = filter_bandpass_select_i ? bp : notch; // see [R06]
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            x1 <= '0;
            x2 <= '0;
            y1 <= '0;
            y2 <= '0;
            out_data_o <= '0;
            out_valid_o <= 1'b0;
        end
        else
        begin
            x1 <= next_x1;
            x2 <= next_x2;
            y1 <= next_y1;
            y2 <= next_y2;
            out_data_o <= next_out;
            out_valid_o <= in_valid_i;
        end
    end

    chk_filter_bypass: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // see [R06]
        in_valid_i && !filter_enable_i |=> out_valid_o && out_data_o == $past(in_data_i))
        else $error("bypassed sample altered");

endmodule : lmtr_filter

// >>> src/lmtr_level_meter.sv
// Behaviour
// [R01] One meter, two-bit channel select
// [R02] AC source wins; else receive DC (code takes DC transmit instead when dc_path_select_i is set)
// [R03] Four-bit code picks DC transmit source
// [R04] Host freezes DC loop before switching
// [R05] AC path uses 8 kHz samples
// [R06] Filter bypass or insert; notch/bandpass
// [R07] Per-response coefficients: RAM or ROM
// [R08] Fixed Q 5, programmable centre
// [R09] DC transmit path decimated to 8 kHz
// [R10] Offset subtracted on DC transmit path
// [R11] Gain one or sixteen
// [R12] Host keeps extra gain low normally
// [R13] Rectifier folds negatives when enabled
// [R14] Eleven-bit count sets integration period
// [R15] Run-once bit: single or continuous
// [R16] Enable starts; completion flag plus interrupt
// [R17] Continuous restarts; flag clears after 125us
// [R18] Single holds flag until enable drops
// [R19] Result written as two bytes
// [R20] 27-bit accumulator, shifted to 16 bits
// [R21] Shift code scales, capped at 1/2048
// [R22] Count plus one samples
// [R23] Enable low aborts and clears
// [R24] Result saturates instead of wrapping
`timescale 1ns/1ps
module lmtr_level_meter
    import lmtr_pkg::*;
#(
    parameter int DEC_LOG2 = 4
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    // Sample timing and sources
    input wire logic sample_tick_i,
    input wire logic [CH_NUM*SMP_W-1:0] ac_transmit_signal_i,
    input wire logic [CH_NUM*SMP_W-1:0] dc_rx_signal_i,
    input wire logic dc_tx_raw_valid_i,
    input wire logic signed [SMP_W-1:0] dc_tx_raw_i,
    input wire logic signed [SMP_W-1:0] dc_offset_i,
    // Source and filter configuration
    input wire logic [1:0] meter_channel_select_i,
    input wire logic ac_source_select_i,
    input wire logic dc_path_select_i,
    input wire logic [3:0] dc_input_select_i,
    input wire logic meter_filter_enable_i,
    input wire logic filter_bandpass_select_i,
    input wire logic notch_coef_from_rom_i,
    input wire logic bandpass_coef_from_rom_i,
    input wire logic [COEF_SET_W-1:0] notch_ram_coef_i,
    input wire logic [COEF_SET_W-1:0] bandpass_ram_coef_i,
    // Gain, rectifier, integrator control
    input wire logic extra_gain_select_i,
    input wire logic rectifier_enable_i,
    input wire logic [CNT_W-1:0] integration_count_i,
    input wire logic single_run_select_i,
    input wire logic meter_enable_i,
    input wire logic [3:0] shift_code_i,
    // Status and result
    output logic [DC_PATH_SELECT_NUM-1:0] dc_source_onehot_o,
    output logic sample_ready_o,
    output logic meter_busy_o,
    output logic measurement_done_flag_o,
    output logic measurement_irq_o,
    output logic [7:0] result_low_o,
    output logic [7:0] result_high_o
);
    typedef enum logic [2:0] {
        LMTR_IDLE = 3'b001,
        LMTR_RUN = 3'b010,
        LMTR_HOLD = 3'b100
    } lmtr_state_t;

    // ----------------------------------------
    // DC transmit source decode
    // ----------------------------------------
    always_comb
    begin
        dc_source_onehot_o = '0;
        unique case (dc_input_select_i) // see [R03]
            DC_SEL_OUTDIFF: dc_source_onehot_o[1] = 1'b1;
            DC_SEL_LINE: dc_source_onehot_o[2] = 1'b1;
            DC_SEL_IO_A: dc_source_onehot_o[3] = 1'b1;
            DC_SEL_IO_B: dc_source_onehot_o[4] = 1'b1;
            DC_SEL_RING: dc_source_onehot_o[5] = 1'b1;
            DC_SEL_HALF: dc_source_onehot_o[6] = 1'b1;
            DC_SEL_OFFS: dc_source_onehot_o[7] = 1'b1;
            DC_SEL_IODIFF: dc_source_onehot_o[8] = 1'b1;
            // Unlisted codes fall back to the feed sense input
            default: dc_source_onehot_o[0] = 1'b1;
        endcase
    end

    // ----------------------------------------
    // DC transmit decimator and offset
    // ----------------------------------------
    logic [DEC_LOG2-1:0] dec_cnt, next_dec_cnt;
    logic signed [SMP_W+DEC_LOG2-1:0] dec_sum, next_dec_sum, dec_add;
    logic signed [SMP_W-1:0] dc_tx_dec, next_dc_tx_dec, dc_tx_comp;

    always_comb
    begin
        dec_add = dec_sum + (SMP_W+DEC_LOG2)'(dc_tx_raw_i);
        next_dec_cnt = dec_cnt;
        next_dec_sum = dec_sum;
        next_dc_tx_dec = dc_tx_dec;
        if (dc_tx_raw_valid_i)
        begin
            next_dec_cnt = dec_cnt + 1'b1;
            if (&dec_cnt)
            begin
                next_dc_tx_dec = SMP_W'(dec_add >>> DEC_LOG2); // see [R09]
                next_dec_sum = '0;
            end
            else
                next_dec_sum = dec_add;
        end
        dc_tx_comp = lmtr_sat16(40'(dc_tx_dec) - 40'(dc_offset_i)); // see [R10]
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            dec_cnt <= '0;
            dec_sum <= '0;
            dc_tx_dec <= '0;
        end
        else
        begin
            dec_cnt <= next_dec_cnt;
            dec_sum <= next_dec_sum;
            dc_tx_dec <= next_dc_tx_dec;
        end
    end

    // ----------------------------------------
    // Source select, filter, gain, rectifier
    // ----------------------------------------
    logic signed [SMP_W-1:0] src_sample, filt_out;
    logic signed [COND_W-1:0] gained, cond;
    logic filt_valid;

    always_comb
    begin
        if (ac_source_select_i)
            src_sample = $signed(ac_transmit_signal_i[meter_channel_select_i*SMP_W +: SMP_W]); // see [R01] [R02]
        else if (dc_path_select_i)
            src_sample = dc_tx_comp;
        else
            src_sample = $signed(dc_rx_signal_i[meter_channel_select_i*SMP_W +: SMP_W]); // see [R01] [R02]
        gained = COND_W'(filt_out);
        if (extra_gain_select_i)
            gained = COND_W'(filt_out) <<< GAIN_SHIFT; // see [R11]
        cond = (rectifier_enable_i && gained < 0) ? -gained : gained; // see [R13]
    end

    // Filter sits in the AC path only; DC sources pass straight through
    lmtr_filter u_filter (
        .ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i),
        .in_valid_i(sample_tick_i), // see [R05]
        .in_data_i(src_sample),
        .filter_enable_i(meter_filter_enable_i && ac_source_select_i),
        .filter_bandpass_select_i(filter_bandpass_select_i),
        .notch_coef_from_rom_i(notch_coef_from_rom_i),
        .bandpass_coef_from_rom_i(bandpass_coef_from_rom_i),
        .notch_ram_coef_i(notch_ram_coef_i),
        .bandpass_ram_coef_i(bandpass_ram_coef_i),
        .out_valid_o(filt_valid),
        .out_data_o(filt_out)
    );

    // ----------------------------------------
    // Sample FIFO
    // ----------------------------------------
    logic pop_valid, pop_ready;
    logic [COND_W-1:0] pop_data;
    lmtr_state_t state, next_state;

    // A held single result stalls draining; new samples drop once full
    assign pop_ready = (state != LMTR_HOLD);

    lmtr_fifo #(
        .WIDTH(COND_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i),
        .in_valid_i(filt_valid),
        .in_ready_o(sample_ready_o),
        .in_data_i(cond),
        .out_valid_o(pop_valid),
        .out_ready_i(pop_ready),
        .out_data_o(pop_data)
    );

    // ----------------------------------------
    // Integrator
    // ----------------------------------------
    logic signed [ACC_W-1:0] acc, next_acc, sum_w, shifted;
    logic [CNT_W-1:0] smp_cnt, next_smp_cnt;
    logic [HOLD_W-1:0] hold_timer, next_hold_timer;
    logic [SMP_W-1:0] result, next_result;
    logic [3:0] shift_amt;
    logic next_flag, next_irq;

    always_comb
    begin
        shift_amt = (shift_code_i > SHIFT_MAX) ? SHIFT_MAX : shift_code_i; // see [R21]
        sum_w = acc + ACC_W'($signed(pop_data)); // see [R20]
        shifted = sum_w >>> shift_amt; // see [R20]
        next_state = state;
        next_acc = acc;
        next_smp_cnt = smp_cnt;
        next_result = result;
        next_flag = measurement_done_flag_o;
        next_irq = 1'b0;
        next_hold_timer = hold_timer;
        // Continuous-mode self clear; a completion below overrides it
        if (state == LMTR_RUN && measurement_done_flag_o)
        begin
            if (hold_timer == '0)
                next_flag = 1'b0; // see [R17]
            else
                next_hold_timer = hold_timer - 1'b1;
        end
        unique case (state)
            LMTR_IDLE:
            begin
                next_acc = '0;
                next_smp_cnt = '0;
                next_flag = 1'b0;
                if (meter_enable_i)
                    next_state = LMTR_RUN; // see [R16]
            end
            LMTR_RUN:
            begin
                if (!meter_enable_i)
                begin
                    next_state = LMTR_IDLE; // see [R23]
                    next_acc = '0;
                    next_smp_cnt = '0;
                    next_flag = 1'b0;
                end
                else if (pop_valid)
                begin
                    if (smp_cnt == integration_count_i) // see [R14] [R22]
                    begin
                        next_result = lmtr_sat16(40'(shifted)); // see [R24] [R19]
                        next_flag = 1'b1; // see [R16]
                        next_irq = 1'b1;
                        next_hold_timer = HOLD_W'(FLAG_HOLD_CYC - 1);
                        next_acc = '0;
                        next_smp_cnt = '0;
                        if (single_run_select_i)
                            next_state = LMTR_HOLD; // see [R15]
                    end
                    else
                    begin
                        next_acc = sum_w;
                        next_smp_cnt = smp_cnt + 1'b1;
                    end
                end
            end
            LMTR_HOLD:
            begin
                if (!meter_enable_i)
                begin
                    next_state = LMTR_IDLE; // see [R18]
                    next_flag = 1'b0;
                end
            end
            default: next_state = LMTR_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            state <= LMTR_IDLE;
            acc <= '0;
            smp_cnt <= '0;
            result <= '0;
            hold_timer <= '0;
            measurement_done_flag_o <= 1'b0;
            measurement_irq_o <= 1'b0;
        end
        else
        begin
            state <= next_state;
            acc <= next_acc;
            smp_cnt <= next_smp_cnt;
            result <= next_result;
            hold_timer <= next_hold_timer;
            measurement_done_flag_o <= next_flag;
            measurement_irq_o <= next_irq;
        end
    end

    assign result_low_o = result[7:0];
    assign result_high_o = result[15:8];
    assign meter_busy_o = (state == LMTR_RUN);

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);

    sequence s_done_cont;
        measurement_irq_o ##0 !single_run_select_i;
    endsequence

    sequence s_hold_enabled;
        state == LMTR_HOLD ##0 meter_enable_i;
    endsequence

    chk_abort_clears: assert property (!meter_enable_i |=> !measurement_done_flag_o // see [R23]
        && state == LMTR_IDLE && acc == '0)
        else $error("enable low did not abort");

    chk_single_hold: assert property (s_hold_enabled |=> measurement_done_flag_o // see [R18]
        && state == LMTR_HOLD)
        else $error("single result not held");

    chk_single_stop: assert property (s_hold_enabled |=> !measurement_irq_o) // see [R15]
        else $error("single run completed twice");

    chk_irq_flag: assert property (measurement_irq_o |-> measurement_done_flag_o // see [R16]
        && $past(meter_enable_i))
        else $error("interrupt without flag");

    chk_cont_restart: assert property (s_done_cont |-> state == LMTR_RUN // see [R17]
        && acc == '0 && smp_cnt == '0)
        else $error("continuous run did not restart");

    chk_flag_selfclr: assert property (measurement_done_flag_o && state == LMTR_RUN // see [R17]
        && meter_enable_i && hold_timer == '0 && !pop_valid |=> !measurement_done_flag_o)
        else $error("flag outlived its hold time");

    chk_flag_timer: assert property (s_done_cont |-> hold_timer == HOLD_W'(FLAG_HOLD_CYC - 1)) // see [R17]
        else $error("flag hold timer not loaded");

    chk_count_match: assert property (measurement_irq_o |-> // see [R22]
        $past(smp_cnt) == $past(integration_count_i))
        else $error("completion at wrong count");

    chk_rect_sign: assert property (filt_valid && rectifier_enable_i |-> !cond[COND_W-1]) // see [R13]
        else $error("rectified sample negative");

endmodule : lmtr_level_meter

// >>> src/lmtr_pkg.sv
package lmtr_pkg;

    // ----------------------------------------
    // Data path widths
    // ----------------------------------------
    localparam int SMP_W = 16;
    localparam int ACC_W = 27;
    localparam int CNT_W = 11;
    localparam int CH_NUM = 4;
    localparam int GAIN_SHIFT = 4;
    localparam int COND_W = SMP_W + GAIN_SHIFT;
    localparam int COEF_W = 16;
    localparam int COEF_FRAC = 14;
    localparam int COEF_SET_W = 3 * COEF_W;
    localparam int FIFO_DEPTH = 4;
    localparam logic [3:0] SHIFT_MAX = 4'hb;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_HZ = 10_000_000;
    localparam int FLAG_HOLD_US = 125;
    localparam int FLAG_HOLD_CYC = FLAG_HOLD_US * (CLK_HZ / 1_000_000);
    localparam int HOLD_W = $clog2(FLAG_HOLD_CYC + 1);

    // ----------------------------------------
    // DC transmit source codes
    // ----------------------------------------
    localparam int DC_PATH_SELECT_NUM = 9;
    localparam logic [3:0] DC_SEL_FEED = 4'h0;
    localparam logic [3:0] DC_SEL_OUTDIFF = 4'h4;
    localparam logic [3:0] DC_SEL_LINE = 4'h9;
    localparam logic [3:0] DC_SEL_IO_A = 4'ha;
    localparam logic [3:0] DC_SEL_IO_B = 4'hb;
    localparam logic [3:0] DC_SEL_RING = 4'hc;
    localparam logic [3:0] DC_SEL_HALF = 4'hd;
    localparam logic [3:0] DC_SEL_OFFS = 4'he;
    localparam logic [3:0] DC_SEL_IODIFF = 4'hf;

    // Built-in coefficient sets {gain, a2, a1}, Q14, 1014 Hz with Q of 5
    localparam logic [COEF_SET_W-1:0] NOTCH_ROM_COEF = {16'h04b6, 16'h3693, 16'h52ab};
    localparam logic [COEF_SET_W-1:0] BP_ROM_COEF = {16'h04b6, 16'h3693, 16'h52ab};

    function automatic logic signed [SMP_W-1:0] lmtr_sat16(input logic signed [39:0] v);
        if (v > 40'sh0000007fff)
            return 16'sh7fff;
        else if (v < -40'sh0000008000)
            return 16'sh8000;
        else
            return v[SMP_W-1:0];
    endfunction : lmtr_sat16

endpackage : lmtr_pkg

// >>> testbench/lmtr_codec_model.sv
`timescale 1ns/1ps
module lmtr_codec_model #(
    parameter int PERIOD = 20
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    // Raw DC level and sample timing
    input wire logic [15:0] raw_level_i,
    output logic sample_tick_o,
    output logic dc_tx_raw_valid_o,
    output logic [15:0] dc_tx_raw_o
);
    int cnt;
    logic raw_slot;

    assign raw_slot = (cnt == 1) || (cnt == PERIOD / 2);

    // Two raw DC samples per tick; data inverted between them so stale values show
    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            cnt <= 0;
            sample_tick_o <= 1'b0;
            dc_tx_raw_valid_o <= 1'b0;
            dc_tx_raw_o <= 16'h0000;
        end
        else
        begin
            cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
            sample_tick_o <= (cnt == 0);
            dc_tx_raw_valid_o <= raw_slot;
            dc_tx_raw_o <= raw_slot ? raw_level_i : ~raw_level_i;
        end
    end
endmodule : lmtr_codec_model

// >>> testbench/lmtr_level_meter_bench.sv
`timescale 1ns/1ps
module lmtr_level_meter_bench;
    import lmtr_pkg::*;
    localparam int PER = 20;
    logic clk = 0, rstn = 0, tick, rvld, acsrc = 1, dcpath = 0, fen = 0, bps = 0, nrom = 1;
    logic brom = 1, gain = 0, rect = 0, once = 1, en = 0, rdy, busy, flag, irq;
    logic [63:0] ac = 0, dcrx = 0;
    logic [15:0] raw, offs = 0, lvl = 0;
    logic [1:0] ch = 0;
    logic [3:0] dsel = 0, shift = 0;
    logic [47:0] ncoef = 0, bcoef = 0;
    logic [10:0] cnt = 0;
    logic [8:0] onehot;
    logic [7:0] rl, rh;
    int n_fail = 0, comparisons = 0, seed = 91, n;
    logic [15:0] last;

    always #50 clk = ~clk;

    lmtr_codec_model #(.PERIOD(PER)) i_codec (.ref_clk_i(clk), .rstn_i(rstn),
        .raw_level_i(lvl), .sample_tick_o(tick), .dc_tx_raw_valid_o(rvld), .dc_tx_raw_o(raw));

    lmtr_level_meter #(.DEC_LOG2(1)) i_dut (.ref_clk_i(clk), .rstn_i(rstn),
        .sample_tick_i(tick), .ac_transmit_signal_i(ac), .dc_rx_signal_i(dcrx),
        .dc_tx_raw_valid_i(rvld), .dc_tx_raw_i(raw), .dc_offset_i(offs),
        .meter_channel_select_i(ch), .ac_source_select_i(acsrc), .dc_path_select_i(dcpath),
        .dc_input_select_i(dsel), .meter_filter_enable_i(fen), .filter_bandpass_select_i(bps),
        .notch_coef_from_rom_i(nrom), .bandpass_coef_from_rom_i(brom),
        .notch_ram_coef_i(ncoef), .bandpass_ram_coef_i(bcoef), .extra_gain_select_i(gain),
        .rectifier_enable_i(rect), .integration_count_i(cnt), .single_run_select_i(once),
        .meter_enable_i(en), .shift_code_i(shift), .dc_source_onehot_o(onehot),
        .sample_ready_o(rdy), .meter_busy_o(busy), .measurement_done_flag_o(flag),
        .measurement_irq_o(irq), .result_low_o(rl), .result_high_o(rh));

    task automatic finish_test;
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : finish_test

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Drive just after the edge so the design never races the bench
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : step

    task automatic wait_flag(input int lim);
        n = 0;
        while (flag !== 1'b1)
        begin
            step(1);
            if (++n > lim)
            begin
                n_fail++;
                $display("ERROR at %0t: no completion", $time);
                finish_test();
            end
        end
    endtask : wait_flag

    function automatic logic [15:0] model(input int x, input int c, input int k);
        longint s;
        s = gain ? x * 16 : x;
        if (rect && s < 0)
            s = -s;
        s = (s * (c + 1)) >>> ((k > 11) ? 11 : k);
        if (s > 32767)
            s = 32767;
        if (s < -32768)
            s = -32768;
        return s[15:0];
    endfunction : model

    task automatic measure(input int c, input int k, input bit dc, input bit sat);
        int x;
        ac = {$random(seed), $random(seed)};
        dcrx = {$random(seed), $random(seed)};
        ncoef = {$random(seed), $random(seed)};
        bcoef = {$random(seed), $random(seed)};
        if (sat)
            ac[ch*16 +: 16] = 16'h7fff;
        x = dc ? $signed(dcrx[ch*16 +: 16]) : $signed(ac[ch*16 +: 16]);
        acsrc = !dc;
        cnt = c[10:0];
        shift = k[3:0];
        once = 1;
        // Stale samples of the old setup must drain while still idle
        step(8);
        en = 1;
        wait_flag((c + 3) * PER + 20);
        check(irq, 1'b1);
        check({rh, rl}, model(x, c, k));
        last = {rh, rl};
        step(PER * 6);
        check(flag, 1'b1);
        check({rh, rl}, last);
        check(rdy, 1'b0);
        en = 0;
        step(1);
        check(flag, 1'b0);
        step(1);
    endtask : measure

    initial
    begin
        step(20);
        rstn = 1;
        check({rh, rl}, 16'h0000);
        check({busy, flag, irq, rdy}, 4'b0001);
        for (int i = 0; i < 16; i++)
        begin
            dsel = i[3:0];
            #1;
            check(onehot, 9'h1 << ((i == 4) ? 1 : (i >= 9) ? i - 7 : 0));
        end
        $display("Test source decode done");
        for (int i = 0; i < 12; i++)
        begin
            ch = i[1:0];
            {gain, rect, bps, nrom, brom} = 5'($random(seed));
            dcpath = 0;
            measure(i % 4, (i * 3) % 16, i[2], 0);
        end
        gain = 1;
        rect = 0;
        measure(3, 0, 0, 1);
        $display("Test single runs done");
        dcpath = 1;
        acsrc = 0;
        dsel = 4'h0;
        lvl = 16'h1234;
        offs = 16'h0034;
        {gain, rect} = 2'b00;
        once = 0;
        cnt = 69;
        shift = 4'h4;
        // Decimator and FIFO settle on the new level before the start
        step(PER * 2);
        en = 1;
        wait_flag(72 * PER);
        check({rh, rl}, model($signed(lvl) - $signed(offs), 69, 4));
        step(1);
        n = 1;
        while (flag === 1'b1 && n < 1300)
        begin
            step(1);
            n++;
        end
        check(n >= 1249 && n <= 1251, 1'b1);
        last = {rh, rl};
        wait_flag(72 * PER);
        check({rh, rl}, model($signed(lvl) - $signed(offs), 69, 4));
        en = 0;
        step(1);
        check({busy, flag}, 2'b00);
        $display("Test continuous run done");
        once = 1;
        cnt = 100;
        en = 1;
        step(PER * 10);
        check(busy, 1'b1);
        en = 0;
        step(2);
        check({busy, flag}, 2'b00);
        check({rh, rl}, last);
        $display("Test abort done");
        finish_test();
    end
endmodule : lmtr_level_meter_bench
